// File: rtl/hwd_decoder.sv
// halfword decoder core plus output register stage
module hwd_misc_dec (
   input wire logic [15:0] hw,
   output hwd_pkg::hwd_op_t op,
   output logic undef,
   output logic is_hint
);
   logic [6:0] mop;
   logic [3:0] hmaj;
   logic [3:0] hmin;
   assign mop = hw[11:5];
   assign hmaj = hw[7:4];
   assign hmin = hw[3:0];
   always_comb begin
      op = hwd_pkg::OP_NONE;
      undef = 1'b0;
      is_hint = 1'b0;
      if (mop[6:2] == 5'h00) begin
         op = hwd_pkg::OP_SP_ADD_IMM; // [RULE11]
      end else if (mop[6:2] == 5'h01) begin
         op = hwd_pkg::OP_SP_SUB_IMM; // [RULE11]
      end else if (mop[6:3] == 4'h2) begin
         unique case (mop[2:1]) // [RULE12]
            2'h0: op = hwd_pkg::OP_SIGNED_HALFWORD_EXTEND;
            2'h1: op = hwd_pkg::OP_SIGNED_BYTE_EXTEND;
            2'h2: op = hwd_pkg::OP_UNSIGNED_HALFWORD_EXTEND;
            2'h3: op = hwd_pkg::OP_UNSIGNED_BYTE_EXTEND;
         endcase
      end else if (mop[6:4] == 3'h2) begin
         op = hwd_pkg::OP_STACK_PUSH; // [RULE13]
      end else if (mop == hwd_pkg::MISC_STATE_CHANGE) begin
         op = hwd_pkg::OP_PROCESSOR_STATE_CHANGE; // [RULE13]
      end else if (mop[6:1] == 6'h28) begin
         op = hwd_pkg::OP_BYTE_SWAP_WORD; // [RULE12]
      end else if (mop[6:1] == 6'h29) begin
         op = hwd_pkg::OP_BYTE_SWAP_HALVES; // [RULE12]
      end else if (mop[6:1] == 6'h2b) begin
         op = hwd_pkg::OP_BYTE_SWAP_SIGNED_HALF; // [RULE12]
      end else if (mop[6:4] == 3'h6) begin
         op = hwd_pkg::OP_STACK_POP; // [RULE13]
      end else if (mop[6:3] == 4'he) begin
         op = hwd_pkg::OP_BREAKPOINT_TRAP; // [RULE14]
      end else if (mop[6:3] == 4'hf) begin
         is_hint = 1'b1; // [RULE14]
         if (hmin != 4'h0) begin
            undef = 1'b1; // [RULE15]
         end else begin
            unique case (hmaj) // [RULE16]
               4'h1: op = hwd_pkg::OP_YIELD_HINT;
               4'h2: op = hwd_pkg::OP_WAIT_EVENT_HINT;
               4'h3: op = hwd_pkg::OP_WAIT_IRQ_HINT;
               4'h4: op = hwd_pkg::OP_SEND_EVENT_HINT;
               default: op = hwd_pkg::OP_NO_OPERATION; // [RULE17]
            endcase
         end
      end else begin
         undef = 1'b1; // [RULE13]
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////

module hwd_decoder (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic hw_valid,
   input wire logic [15:0] hw,
   output hwd_pkg::hwd_dec_t dec
);
   logic [5:0] top6;
   logic [3:0] major;
   logic [2:0] minor;
   logic [3:0] sub;
   logic [3:0] brop;
   logic wide;
   hwd_pkg::hwd_op_t misc_op;
   logic misc_undef;
   logic misc_hint;
   hwd_pkg::hwd_dec_t next_dec;

   assign top6 = hw[15:10];
   assign major = hw[15:12];
   assign minor = hw[11:9];
   assign sub = hw[9:6];
   assign brop = hw[11:8];
   assign wide = (hw[15:11] == hwd_pkg::WIDE_A) || (hw[15:11] == hwd_pkg::WIDE_B)
      || (hw[15:11] == hwd_pkg::WIDE_C); // [RULE1]

   hwd_misc_dec u_misc (
      .hw(hw),
      .op(misc_op),
      .undef(misc_undef),
      .is_hint(misc_hint)
   );

   ////////////////////////////////////////////////////////////////////////////
   // classification
   always_comb begin
      next_dec = '0;
      next_dec.valid = hw_valid;
      next_dec.cls = hwd_pkg::HWD_CL_OTHER;
      next_dec.op = hwd_pkg::OP_NONE;
      if (wide) begin
         next_dec.cls = hwd_pkg::HWD_CL_WIDE; // [RULE1]
         next_dec.is_wide = 1'b1;
      end else if (top6 == hwd_pkg::TOP_DP) begin
         next_dec.cls = hwd_pkg::HWD_CL_DP; // [RULE2]
         unique case (sub) // [RULE3] [RULE4]
            4'h0: next_dec.op = hwd_pkg::OP_CONJ;
            4'h1: next_dec.op = hwd_pkg::OP_EXCLUSIVE_OR;
            4'h2: next_dec.op = hwd_pkg::OP_SHIFT_LEFT_LOGICAL;
            4'h3: next_dec.op = hwd_pkg::OP_SHIFT_RIGHT_LOGICAL;
            4'h4: next_dec.op = hwd_pkg::OP_SHIFT_RIGHT_ARITH;
            4'h5: next_dec.op = hwd_pkg::OP_ADD_WITH_CARRY;
            4'h6: next_dec.op = hwd_pkg::OP_SUBTRACT_WITH_BORROW;
            4'h7: next_dec.op = hwd_pkg::OP_ROTATE_RIGHT;
            4'h8: next_dec.op = hwd_pkg::OP_TEST_FLAGS_CONJ;
            4'h9: next_dec.op = hwd_pkg::OP_NEGATE_FROM_ZERO;
            4'ha: next_dec.op = hwd_pkg::OP_COMPARE_REGS;
            4'hb: next_dec.op = hwd_pkg::OP_COMPARE_NEGATED;
            4'hc: next_dec.op = hwd_pkg::OP_INCLUSIVE_OR;
            4'hd: next_dec.op = hwd_pkg::OP_PRODUCT_TWO_REGS;
            4'he: next_dec.op = hwd_pkg::OP_BIT_CLEAR;
            4'hf: next_dec.op = hwd_pkg::OP_BITWISE_INVERT;
         endcase
      end else if (top6 == hwd_pkg::TOP_SPECIAL) begin
         next_dec.cls = hwd_pkg::HWD_CL_SPECIAL; // [RULE2]
         if (sub[3:2] == 2'h0) begin
            next_dec.op = hwd_pkg::OP_REG_ADD; // [RULE5]
         end else if (sub == 4'h4) begin
            next_dec.unpredictable = 1'b1; // [RULE5] [RULE19]
         end else if (sub[3:2] == 2'h1) begin
            next_dec.op = hwd_pkg::OP_REG_COMPARE; // [RULE5]
         end else if (sub[3:2] == 2'h2) begin
            next_dec.op = hwd_pkg::OP_REGISTER_COPY; // [RULE5]
         end else if (sub[1] == 1'b0) begin
            next_dec.op = hwd_pkg::OP_BRANCH_EXCHANGE; // [RULE6]
         end else begin
            next_dec.op = hwd_pkg::OP_BRANCH_LINK_EXCHANGE; // [RULE6]
         end
      end else if (major == hwd_pkg::TOP_LS_REG) begin
         next_dec.cls = hwd_pkg::HWD_CL_LOADSTORE; // [RULE7]
         unique case (minor) // [RULE8]
            3'h0: next_dec.op = hwd_pkg::OP_WORD_STORE;
            3'h1: next_dec.op = hwd_pkg::OP_HALFWORD_STORE;
            3'h2: next_dec.op = hwd_pkg::OP_BYTE_STORE;
            3'h3: next_dec.op = hwd_pkg::OP_SIGNED_BYTE_LOAD;
            3'h4: next_dec.op = hwd_pkg::OP_WORD_LOAD;
            3'h5: next_dec.op = hwd_pkg::OP_HALFWORD_LOAD;
            3'h6: next_dec.op = hwd_pkg::OP_BYTE_LOAD;
            3'h7: next_dec.op = hwd_pkg::OP_SIGNED_HALFWORD_LOAD;
         endcase
      end else if (major == hwd_pkg::TOP_LS_WORD) begin
         next_dec.cls = hwd_pkg::HWD_CL_LOADSTORE; // [RULE7]
         next_dec.op = minor[2] ? hwd_pkg::OP_WORD_LOAD : hwd_pkg::OP_WORD_STORE; // [RULE9]
      end else if (major == hwd_pkg::TOP_LS_BYTE) begin
         next_dec.cls = hwd_pkg::HWD_CL_LOADSTORE; // [RULE7]
         next_dec.op = minor[2] ? hwd_pkg::OP_BYTE_LOAD : hwd_pkg::OP_BYTE_STORE; // [RULE9]
      end else if (major == hwd_pkg::TOP_LS_HALF) begin
         next_dec.cls = hwd_pkg::HWD_CL_LOADSTORE; // [RULE7]
         next_dec.op = minor[2] ? hwd_pkg::OP_HALFWORD_LOAD
            : hwd_pkg::OP_HALFWORD_STORE; // [RULE9]
      end else if (major == hwd_pkg::TOP_LS_SP) begin
         next_dec.cls = hwd_pkg::HWD_CL_LOADSTORE; // [RULE7]
         next_dec.op = minor[2] ? hwd_pkg::OP_SP_WORD_LOAD
            : hwd_pkg::OP_SP_WORD_STORE; // [RULE10]
      end else if (major == hwd_pkg::TOP_MISC) begin
         next_dec.cls = misc_hint ? hwd_pkg::HWD_CL_HINT : hwd_pkg::HWD_CL_MISC; // [RULE14]
         next_dec.op = misc_op;
         next_dec.undefined = misc_undef; // [RULE13] [RULE15] [RULE19]
      end else if (major == hwd_pkg::TOP_BRANCH) begin
         next_dec.cls = hwd_pkg::HWD_CL_BRANCH;
         if (brop == hwd_pkg::BR_UDF) begin
            next_dec.op = hwd_pkg::OP_PERMANENT_UNDEFINED; // [RULE18]
            next_dec.undefined = 1'b1; // [RULE19]
         end else if (brop == hwd_pkg::BR_SVC) begin
            next_dec.op = hwd_pkg::OP_SUPERVISOR_CALL; // [RULE18]
         end else begin
            next_dec.op = hwd_pkg::OP_COND_BRANCH; // [RULE18]
         end
      end
      if (!hw_valid) begin
         next_dec.undefined = 1'b0;
         next_dec.unpredictable = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         dec <= '0;
      end else begin
         dec <= next_dec;
      end
   end
endmodule

// File: rtl/hwd_pkg.sv
// constants and types for the halfword instruction decoder
// What this block does
// RULE1 - top five bits 11101, 11110 or 11111 mark a 32-bit instruction's first half
// RULE2 - top six bits 010001 select special ops, 010000 select data processing
// RULE3 - data processing opcodes 0000 to 0111: conjunction, xor, shifts, carry add, borrow subtract, rotate
// RULE4 - data processing opcodes 1000 to 1111: test, negate, compares, or, multiply, clear, invert
// RULE5 - special opcodes: 00xx add, 0101/011x compare, 10xx copy, 0100 unpredictable
// RULE6 - special opcodes 110x branch exchange, 111x branch link exchange, register target
// RULE7 - single load/store when major selector is 0101, 011x or 100x
// RULE8 - major 0101 uses minor selector for eight register-offset load/store kinds
// RULE9 - immediate offset: 0110 word, 0111 byte, 1000 halfword; minor top bit load
// RULE10 - major 1001 is stack-relative word store or load by minor top bit
// RULE11 - misc 00000xx adds immediate to stack pointer, 00001xx subtracts
// RULE12 - misc extend opcodes 001000x..001011x and byte swaps 101000x, 101001x, 101011x
// RULE13 - misc 010xxxx push, 110xxxx pop, 0110011 state change; others undefined
// RULE14 - misc 1110xxx breakpoint, 1111xxx hint space
// RULE15 - hint with nonzero minor field is undefined
// RULE16 - hint 0000 no operation, 0001 yield, 0010 wait event, 0011 wait irq, 0100 send event
// RULE17 - other hints with zero minor field execute as no operation
// RULE18 - top bits 1101: branch unless 111x; 1110 permanent undefined, 1111 supervisor call
// RULE19 - one undefined flag for all undefined encodings, separate unpredictable flag
package hwd_pkg;
   localparam int HW_W = 16;
   localparam logic [4:0] WIDE_A = 5'h1d;
   localparam logic [4:0] WIDE_B = 5'h1e;
   localparam logic [4:0] WIDE_C = 5'h1f;
   localparam logic [5:0] TOP_DP = 6'h10;
   localparam logic [5:0] TOP_SPECIAL = 6'h11;
   localparam logic [3:0] TOP_LS_REG = 4'h5;
   localparam logic [3:0] TOP_LS_WORD = 4'h6;
   localparam logic [3:0] TOP_LS_BYTE = 4'h7;
   localparam logic [3:0] TOP_LS_HALF = 4'h8;
   localparam logic [3:0] TOP_LS_SP = 4'h9;
   localparam logic [3:0] TOP_MISC = 4'hb;
   localparam logic [3:0] TOP_BRANCH = 4'hd;
   localparam logic [3:0] BR_UDF = 4'he;
   localparam logic [3:0] BR_SVC = 4'hf;
   localparam logic [6:0] MISC_STATE_CHANGE = 7'h33;

   typedef enum logic [4:0] {
      HWD_CL_NONE, HWD_CL_WIDE, HWD_CL_DP, HWD_CL_SPECIAL, HWD_CL_LOADSTORE,
      HWD_CL_MISC, HWD_CL_HINT, HWD_CL_BRANCH, HWD_CL_OTHER
   } hwd_class_t;

   typedef enum logic [5:0] {
      OP_NONE,
      OP_CONJ, OP_EXCLUSIVE_OR, OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
      OP_SHIFT_RIGHT_ARITH, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_ROTATE_RIGHT,
      OP_TEST_FLAGS_CONJ, OP_NEGATE_FROM_ZERO, OP_COMPARE_REGS, OP_COMPARE_NEGATED,
      OP_INCLUSIVE_OR, OP_PRODUCT_TWO_REGS, OP_BIT_CLEAR, OP_BITWISE_INVERT,
      OP_REG_ADD, OP_REG_COMPARE, OP_REGISTER_COPY, OP_BRANCH_EXCHANGE,
      OP_BRANCH_LINK_EXCHANGE,
      OP_WORD_STORE, OP_HALFWORD_STORE, OP_BYTE_STORE, OP_SIGNED_BYTE_LOAD,
      OP_WORD_LOAD, OP_HALFWORD_LOAD, OP_BYTE_LOAD, OP_SIGNED_HALFWORD_LOAD,
      OP_SP_WORD_STORE, OP_SP_WORD_LOAD,
      OP_SP_ADD_IMM, OP_SP_SUB_IMM, OP_SIGNED_HALFWORD_EXTEND, OP_SIGNED_BYTE_EXTEND,
      OP_UNSIGNED_HALFWORD_EXTEND, OP_UNSIGNED_BYTE_EXTEND, OP_BYTE_SWAP_WORD,
      OP_BYTE_SWAP_HALVES, OP_BYTE_SWAP_SIGNED_HALF, OP_STACK_PUSH, OP_STACK_POP,
      OP_PROCESSOR_STATE_CHANGE, OP_BREAKPOINT_TRAP,
      OP_NO_OPERATION, OP_YIELD_HINT, OP_WAIT_EVENT_HINT, OP_WAIT_IRQ_HINT,
      OP_SEND_EVENT_HINT,
      OP_COND_BRANCH, OP_PERMANENT_UNDEFINED, OP_SUPERVISOR_CALL
   } hwd_op_t;

   typedef struct packed {
      logic valid;
      hwd_class_t cls;
      hwd_op_t op;
      logic is_wide;
      logic undefined;
      logic unpredictable;
   } hwd_dec_t;
endpackage

// File: verif/hwd_monitor.sv
// concurrent checks on the halfword decoder ports
module hwd_monitor (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic hw_valid,
   input wire logic [15:0] hw,
   input wire hwd_pkg::hwd_dec_t dec
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   a_wide_flag_set: assert property (
      $past(reset_n) |-> dec.is_wide == ($past(hw[15:11]) >= 5'h1d))
      else $error("wide flag wrong");
   a_dp_op_map: assert property (
      $past(reset_n) && $past(hw[15:10]) == 6'h10 |-> dec.cls == hwd_pkg::HWD_CL_DP
      && dec.op == hwd_pkg::hwd_op_t'(int'(hwd_pkg::OP_CONJ) + $past(hw[9:6])))
      else $error("data processing op wrong");
   a_special_class: assert property (
      $past(reset_n) && $past(hw[15:10]) == 6'h11 |-> dec.cls == hwd_pkg::HWD_CL_SPECIAL)
      else $error("special class wrong");
   a_unpred_flag: assert property (
      $past(reset_n)
      |-> dec.unpredictable == ($past(hw_valid) && $past(hw[15:6]) == 10'h114))
      else $error("unpredictable flag wrong");
   a_perm_undef: assert property (
      $past(reset_n) && $past(hw[15:8]) == 8'hde |-> dec.op ==
      hwd_pkg::OP_PERMANENT_UNDEFINED && dec.undefined == $past(hw_valid))
      else $error("permanent undefined wrong");
   a_svc_not_undef: assert property (
      $past(reset_n) && $past(hw[15:8]) == 8'hdf
      |-> dec.op == hwd_pkg::OP_SUPERVISOR_CALL && !dec.undefined)
      else $error("supervisor call wrong");
   a_hint_minor_bad: assert property (
      $past(reset_n) && $past(hw[15:8]) == 8'hbf && $past(hw[3:0]) != 4'h0
      |-> dec.cls == hwd_pkg::HWD_CL_HINT && dec.undefined == $past(hw_valid))
      else $error("hint minor field wrong");
   a_ls_reg_map: assert property (
      $past(reset_n) && $past(hw[15:12]) == 4'h5 |-> dec.op ==
      hwd_pkg::hwd_op_t'(int'(hwd_pkg::OP_WORD_STORE) + $past(hw[11:9])))
      else $error("register offset load store wrong");
   a_valid_follow: assert property (
      $past(reset_n) |-> dec.valid == $past(hw_valid))
      else $error("valid not carried");
   a_reset_clears: assert property (!$past(reset_n) |-> dec == '0)
      else $error("output not cleared by reset");
   c_wide: cover property ($past(reset_n) && dec.is_wide);
   c_hint_undef: cover property (dec.cls == hwd_pkg::HWD_CL_HINT && dec.undefined);
   c_svc: cover property (dec.op == hwd_pkg::OP_SUPERVISOR_CALL);
endmodule
bind hwd_decoder hwd_monitor mon_u (.clk(clk), .reset_n(reset_n), .hw_valid(hw_valid), .hw(hw),
   .dec(dec));

// File: verif/hwd_fetch_model.sv
// fetch stage model presenting one halfword per cycle
module hwd_fetch_model (
   input wire logic clk,
   output logic hw_valid,
   output logic [15:0] hw
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      hw_valid = 1'b0;
      hw = 16'h0000;
   end
   task automatic present(input logic [15:0] h, input logic v);
      #1;
      hw = h;
      hw_valid = v;
      @(posedge clk);
   endtask
endmodule

// File: verif/hwd_decoder_tb_top.sv
// self-checking bench for the halfword decoder
module hwd_decoder_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic hw_valid;
   logic [15:0] hw;
   logic [15:0] lfsr = 16'hc091;
   hwd_pkg::hwd_dec_t dec;
   hwd_pkg::hwd_dec_t exp_q[$];
   int mismatches = 0;
   int n_compared = 0;
   always #2 clk = ~clk;
   hwd_fetch_model fetch_u (.clk(clk), .hw_valid(hw_valid), .hw(hw));
   hwd_decoder dut_u (.clk(clk), .reset_n(reset_n), .hw_valid(hw_valid), .hw(hw), .dec(dec));
   function automatic logic [15:0] next_lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic hwd_pkg::hwd_op_t opx(input hwd_pkg::hwd_op_t b, input int k);
      return hwd_pkg::hwd_op_t'(int'(b) + k);
   endfunction
   function automatic hwd_pkg::hwd_dec_t ref_dec(input logic [15:0] h);
      hwd_pkg::hwd_dec_t d;
      logic [6:0] m;
      logic [3:0] o;
      d = '0;
      m = h[11:5];
      o = h[9:6];
      d.cls = hwd_pkg::HWD_CL_OTHER;
      if (h[15:11] >= 5'h1d) begin
         d.cls = hwd_pkg::HWD_CL_WIDE;
         d.is_wide = 1'b1;
      end else if (h[15:10] == 6'h10) begin
         d.cls = hwd_pkg::HWD_CL_DP;
         d.op = opx(hwd_pkg::OP_CONJ, o);
      end else if (h[15:10] == 6'h11) begin
         d.cls = hwd_pkg::HWD_CL_SPECIAL;
         d.unpredictable = (o == 4'h4);
         if (o[3:2] == 2'h0) d.op = hwd_pkg::OP_REG_ADD;
         else if (o == 4'h5 || o[3:1] == 3'h3) d.op = hwd_pkg::OP_REG_COMPARE;
         else if (o[3:2] == 2'h2) d.op = hwd_pkg::OP_REGISTER_COPY;
         else if (o[3:2] == 2'h3) d.op = opx(hwd_pkg::OP_BRANCH_EXCHANGE, o[1]);
      end else if (h[15:12] inside {[4'h5:4'h9]}) begin
         d.cls = hwd_pkg::HWD_CL_LOADSTORE;
         case (h[15:12])
            4'h5: d.op = opx(hwd_pkg::OP_WORD_STORE, h[11:9]);
            4'h6: d.op = opx(hwd_pkg::OP_WORD_STORE, {h[11], 2'h0});
            4'h7: d.op = opx(hwd_pkg::OP_WORD_STORE, {h[11], 2'h2});
            4'h8: d.op = opx(hwd_pkg::OP_WORD_STORE, {h[11], 2'h1});
            default: d.op = opx(hwd_pkg::OP_SP_WORD_STORE, h[11]);
         endcase
      end else if (h[15:12] == 4'hb) begin
         d.cls = hwd_pkg::HWD_CL_MISC;
         if (m[6:3] == 4'h0) d.op = opx(hwd_pkg::OP_SP_ADD_IMM, m[2]);
         else if (m[6:3] == 4'h2)
            d.op = opx(hwd_pkg::OP_SIGNED_HALFWORD_EXTEND, m[2:1]);
         else if (m[6:4] == 3'h2) d.op = hwd_pkg::OP_STACK_PUSH;
         else if (m[6:4] == 3'h6) d.op = hwd_pkg::OP_STACK_POP;
         else if (m == 7'h33) d.op = hwd_pkg::OP_PROCESSOR_STATE_CHANGE;
         else if (m[6:3] == 4'ha && m[2:1] != 2'h2)
            d.op = opx(hwd_pkg::OP_BYTE_SWAP_WORD, int'(m[2]) + int'(m[1]));
         else if (m[6:3] == 4'he) d.op = hwd_pkg::OP_BREAKPOINT_TRAP;
         else if (m[6:3] == 4'hf) begin
            d.cls = hwd_pkg::HWD_CL_HINT;
            if (h[3:0] != 4'h0) d.undefined = 1'b1;
            else if (h[7:4] < 4'h5) d.op = opx(hwd_pkg::OP_NO_OPERATION, h[7:4]);
            else d.op = hwd_pkg::OP_NO_OPERATION;
         end else d.undefined = 1'b1;
      end else if (h[15:12] == 4'hd) begin
         d.cls = hwd_pkg::HWD_CL_BRANCH;
         d.op = hwd_pkg::OP_COND_BRANCH;
         if (h[11:8] == 4'hf) d.op = hwd_pkg::OP_SUPERVISOR_CALL;
         if (h[11:8] == 4'he) d.op = hwd_pkg::OP_PERMANENT_UNDEFINED;
         d.undefined = (h[11:8] == 4'he);
      end
      return d;
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   task automatic send(input logic [15:0] h, input logic v);
      hwd_pkg::hwd_dec_t e;
      e = ref_dec(h);
      e.valid = v;
      e.undefined = e.undefined & v;
      e.unpredictable = e.unpredictable & v;
      fetch_u.present(h, v);
      exp_q.push_back(e);
   endtask
   task automatic check_dec(input hwd_pkg::hwd_dec_t e, input hwd_pkg::hwd_dec_t g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("BAD dec expected %h seen %h", e, g);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      #3;
      if (exp_q.size() > 0) begin
         check_dec(exp_q.pop_front(), dec);
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 65536; i++) send(16'(i), 1'b1);
      for (int i = 0; i < 600; i++) begin
         lfsr = next_lfsr(lfsr);
         send(lfsr, lfsr[3]);
      end
      reset_n <= 1'b0;
      @(posedge clk);
      exp_q.push_back('0);
      @(posedge clk);
      reset_n <= 1'b1;
      send(16'hbf30, 1'b1);
      for (int k = 0; k < 8 && exp_q.size() > 0; k++) @(posedge clk);
      if (exp_q.size() > 0) mismatches++;
      give_verdict();
   end
endmodule
